/* File: hdl/fsac_pkg.sv */
// constants for the flash self-access controller: register map, fields, resets.
// assumes an 8-bit register port on the core clock and a flash macro
// with read data valid in the same cycle as the read strobe and a done pulse for program and erase.
package fsac_pkg;
  localparam logic [2:0] FSAC_DATA_LOW = 3'h0;
  localparam logic [2:0] FSAC_DATA_HIGH = 3'h1;
  localparam logic [2:0] FSAC_ADDR_LOW = 3'h2;
  localparam logic [2:0] FSAC_ADDR_HIGH = 3'h3;
  localparam logic [2:0] FSAC_CONTROL = 3'h4;
  localparam logic [2:0] FSAC_UNLOCK = 3'h5;

  // control register bit positions
  localparam int FSAC_B_RD = 0;
  localparam int FSAC_B_WR = 1;
  localparam int FSAC_B_PROG_ENABLE = 2;
  localparam int FSAC_B_ERR = 3;
  localparam int FSAC_B_FREE = 4;
  localparam int FSAC_B_LATCH_ONLY_SEL = 5;
  localparam int FSAC_B_CFG_SPACE_SEL = 6;

  localparam logic [7:0] FSAC_KEY1 = 8'h55;
  localparam logic [7:0] FSAC_KEY2 = 8'hAA;
  localparam logic [13:0] FSAC_BLANK = 14'h3FFF;
  localparam logic [14:0] FSAC_PTR_RST = 15'h0000;
  localparam logic [13:0] FSAC_WORD_RST = 14'h0000;
  localparam logic [7:0] FSAC_BYTE_ZERO = 8'h00;
  localparam logic [0:0] FSAC_ADRH_TOP = 1'h1;
  localparam logic [1:0] FSAC_DATH_TOP = 2'h0;
  localparam logic [0:0] FSAC_CON_TOP = 1'h1;

  // configuration-space offsets, region base 8000h
  localparam logic [14:0] FSAC_UID_FIRST = 15'h0000;
  localparam logic [14:0] FSAC_UID_LAST = 15'h0003;
  localparam logic [14:0] FSAC_ID_FIRST = 15'h0005;
  localparam logic [14:0] FSAC_CW_LAST = 15'h0008;

  localparam int FSAC_LATCHES = 32;
  localparam logic [4:0] FSAC_LAST_LATCH = 5'h1F;
  localparam logic [4:0] FSAC_IDX_RST = 5'h00;

  typedef enum logic [1:0] {
    FSAC_UL_NONE,
    FSAC_UL_FIRST,
    FSAC_UL_OPEN
  } fsac_unlock_e;
endpackage : fsac_pkg

/* File: hdl/fsac_ctrl.sv */
// flash self-access controller: register file, unlock, latches, read/program/erase.
// assumes the flash macro returns read data in the same cycle as FL_RD_O and
// pulses FL_DONE_I once a program or erase has finished.
module fsac_ctrl (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [13:0] FL_RDATA_I,
  input wire logic FL_DONE_I,
  output logic [14:0] FL_ADDR_O,
  output logic FL_CFG_O,
  output logic FL_RD_O,
  output logic FL_WE_O,
  output logic [13:0] FL_WDATA_O,
  output logic FL_PROG_O,
  output logic FL_ERASE_O,
  output logic BUSY_O
);
  typedef enum logic [2:0] {
    FSAC_ST_IDLE,
    FSAC_ST_READ,
    FSAC_ST_LATCH,
    FSAC_ST_LOAD,
    FSAC_ST_WAIT
  } fsac_state_e;

  typedef struct packed {
    fsac_state_e st;
    logic [14:0] ptr;
    logic [13:0] word;
    logic cfg_space_sel;
    logic latch_only_sel;
    logic free;
    logic err;
    logic prog_enable;
    logic wr;
    logic rd;
    logic rd_ok;
    fsac_pkg::fsac_unlock_e ul;
    logic [4:0] idx;
    logic [fsac_pkg::FSAC_LATCHES-1:0][13:0] latch;
    logic [7:0] rdata;
    logic [14:0] fl_addr;
    logic fl_cfg;
    logic fl_rd;
    logic fl_we;
    logic [13:0] fl_wdata;
    logic fl_prog;
    logic fl_erase;
  } fsac_state_s;

  fsac_state_s s_reg;
  fsac_state_s s_next;

  logic rd_allowed;
  logic wr_allowed_ptr;
  logic wr_allowed_fl;
  logic [14:0] fl_target;
  logic [7:0] ctrl_view;

  always_comb begin
    rd_allowed = 1'b1;
    wr_allowed_ptr = 1'b1;
    wr_allowed_fl = 1'b1;
    fl_target = {s_reg.ptr[14:5], s_reg.idx};
    if (s_reg.cfg_space_sel) begin
      // the unused offset between user IDs and identification reads as zero
      rd_allowed = (s_reg.ptr <= fsac_pkg::FSAC_UID_LAST) ||
        (s_reg.ptr >= fsac_pkg::FSAC_ID_FIRST && s_reg.ptr <= fsac_pkg::FSAC_CW_LAST);
      wr_allowed_ptr = s_reg.ptr >= fsac_pkg::FSAC_UID_FIRST &&
        s_reg.ptr <= fsac_pkg::FSAC_UID_LAST;
      wr_allowed_fl = fl_target <= fsac_pkg::FSAC_UID_LAST;
    end
  end

  always_comb begin
    ctrl_view = {fsac_pkg::FSAC_CON_TOP, s_reg.cfg_space_sel, s_reg.latch_only_sel, s_reg.free,
      s_reg.err, s_reg.prog_enable, s_reg.wr, s_reg.rd};
  end

  always_comb begin
    s_next = s_reg;
    s_next.fl_rd = 1'b0;
    s_next.fl_we = 1'b0;
    s_next.fl_prog = 1'b0;
    s_next.fl_erase = 1'b0;
    s_next.rdata = fsac_pkg::FSAC_BYTE_ZERO;

    if (RD_I) begin
      unique case (ADDR_I)
        fsac_pkg::FSAC_DATA_LOW: s_next.rdata = s_reg.word[7:0];
        fsac_pkg::FSAC_DATA_HIGH: s_next.rdata = {fsac_pkg::FSAC_DATH_TOP, s_reg.word[13:8]};
        fsac_pkg::FSAC_ADDR_LOW: s_next.rdata = s_reg.ptr[7:0];
        fsac_pkg::FSAC_ADDR_HIGH: s_next.rdata = {fsac_pkg::FSAC_ADRH_TOP, s_reg.ptr[14:8]};
        fsac_pkg::FSAC_CONTROL: s_next.rdata = ctrl_view;
        // unlock register is write-only and reads zero, like unmapped offsets
        default: s_next.rdata = fsac_pkg::FSAC_BYTE_ZERO;
      endcase
    end

    if (WR_I) begin
      // a data, address or unmapped register write between the two keys breaks the sequence
      if (ADDR_I != fsac_pkg::FSAC_UNLOCK && ADDR_I != fsac_pkg::FSAC_CONTROL) begin
        s_next.ul = fsac_pkg::FSAC_UL_NONE;
      end
      unique case (ADDR_I)
        fsac_pkg::FSAC_DATA_LOW: s_next.word[7:0] = WDATA_I;
        fsac_pkg::FSAC_DATA_HIGH: s_next.word[13:8] = WDATA_I[5:0];
        fsac_pkg::FSAC_ADDR_LOW: s_next.ptr[7:0] = WDATA_I;
        fsac_pkg::FSAC_ADDR_HIGH: s_next.ptr[14:8] = WDATA_I[6:0];
        fsac_pkg::FSAC_UNLOCK: begin
          if (WDATA_I == fsac_pkg::FSAC_KEY1) begin
            s_next.ul = fsac_pkg::FSAC_UL_FIRST;
          end else if (WDATA_I == fsac_pkg::FSAC_KEY2 && s_reg.ul == fsac_pkg::FSAC_UL_FIRST) begin
            s_next.ul = fsac_pkg::FSAC_UL_OPEN;
          end else begin
            s_next.ul = fsac_pkg::FSAC_UL_NONE;
          end
        end
        fsac_pkg::FSAC_CONTROL: begin
          s_next.cfg_space_sel = WDATA_I[fsac_pkg::FSAC_B_CFG_SPACE_SEL];
          s_next.latch_only_sel = WDATA_I[fsac_pkg::FSAC_B_LATCH_ONLY_SEL];
          s_next.prog_enable = WDATA_I[fsac_pkg::FSAC_B_PROG_ENABLE];
          s_next.err = WDATA_I[fsac_pkg::FSAC_B_ERR];
          // only the free bit is frozen while an operation runs
          if (s_reg.st == FSAC_ST_IDLE) begin
            s_next.free = WDATA_I[fsac_pkg::FSAC_B_FREE];
          end
          if (WDATA_I[fsac_pkg::FSAC_B_WR]) begin
            // error stays set until the operation ends normally or a control write clears it
            s_next.err = 1'b1;
            s_next.ul = fsac_pkg::FSAC_UL_NONE;
            if (s_reg.st == FSAC_ST_IDLE && s_reg.ul == fsac_pkg::FSAC_UL_OPEN &&
                s_reg.prog_enable) begin
              if (WDATA_I[fsac_pkg::FSAC_B_FREE]) begin
                // erase of the protected configuration row is refused
                if (!WDATA_I[fsac_pkg::FSAC_B_CFG_SPACE_SEL]) begin
                  s_next.wr = 1'b1;
                  s_next.st = FSAC_ST_WAIT;
                  s_next.fl_erase = 1'b1;
                  s_next.fl_cfg = 1'b0;
                  s_next.fl_addr = {s_reg.ptr[14:5], fsac_pkg::FSAC_IDX_RST};
                end
              end else begin
                s_next.wr = 1'b1;
                s_next.st = FSAC_ST_LATCH;
              end
            end
          end else if (WDATA_I[fsac_pkg::FSAC_B_RD] && s_reg.st == FSAC_ST_IDLE) begin
            s_next.rd = 1'b1;
            s_next.st = FSAC_ST_READ;
            s_next.rd_ok = rd_allowed;
            s_next.fl_rd = rd_allowed;
            s_next.fl_cfg = s_reg.cfg_space_sel;
            s_next.fl_addr = s_reg.ptr;
          end
        end
        default: s_next.ul = fsac_pkg::FSAC_UL_NONE;
      endcase
    end

    unique case (s_reg.st)
      FSAC_ST_IDLE: begin
      end
      FSAC_ST_READ: begin
        s_next.word = s_reg.rd_ok ? FL_RDATA_I : fsac_pkg::FSAC_WORD_RST;
        s_next.rd = 1'b0;
        s_next.st = FSAC_ST_IDLE;
      end
      FSAC_ST_LATCH: begin
        // a protected configuration location keeps its latch blank
        if (wr_allowed_ptr) begin
          s_next.latch[s_reg.ptr[4:0]] = s_reg.word;
        end
        s_next.idx = fsac_pkg::FSAC_IDX_RST;
        if (s_reg.latch_only_sel) begin
          s_next.wr = 1'b0;
          s_next.err = 1'b0;
          s_next.st = FSAC_ST_IDLE;
        end else begin
          s_next.st = FSAC_ST_LOAD;
        end
      end
      FSAC_ST_LOAD: begin
        // one latch per cycle keeps the macro port narrow at the cost of 32 cycles
        s_next.fl_addr = fl_target;
        s_next.fl_cfg = s_reg.cfg_space_sel;
        s_next.fl_wdata = s_reg.latch[s_reg.idx];
        s_next.fl_we = wr_allowed_fl;
        s_next.idx = s_reg.idx + 5'h01;
        if (s_reg.idx == fsac_pkg::FSAC_LAST_LATCH) begin
          s_next.fl_prog = 1'b1;
          s_next.st = FSAC_ST_WAIT;
        end
      end
      FSAC_ST_WAIT: begin
        if (FL_DONE_I) begin
          s_next.wr = 1'b0;
          s_next.free = 1'b0;
          s_next.err = 1'b0;
          for (int i = 0; i < fsac_pkg::FSAC_LATCHES; i++) begin
            s_next.latch[i] = fsac_pkg::FSAC_BLANK;
          end
          s_next.st = FSAC_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      s_reg.st <= FSAC_ST_IDLE;
      s_reg.ptr <= fsac_pkg::FSAC_PTR_RST;
      s_reg.word <= fsac_pkg::FSAC_WORD_RST;
      s_reg.cfg_space_sel <= 1'b0;
      s_reg.latch_only_sel <= 1'b0;
      s_reg.free <= 1'b0;
      s_reg.err <= 1'b0;
      s_reg.prog_enable <= 1'b0;
      s_reg.wr <= 1'b0;
      s_reg.rd <= 1'b0;
      s_reg.rd_ok <= 1'b0;
      s_reg.ul <= fsac_pkg::FSAC_UL_NONE;
      s_reg.idx <= fsac_pkg::FSAC_IDX_RST;
      for (int i = 0; i < fsac_pkg::FSAC_LATCHES; i++) begin
        s_reg.latch[i] <= fsac_pkg::FSAC_BLANK;
      end
      s_reg.rdata <= fsac_pkg::FSAC_BYTE_ZERO;
      s_reg.fl_addr <= fsac_pkg::FSAC_PTR_RST;
      s_reg.fl_cfg <= 1'b0;
      s_reg.fl_rd <= 1'b0;
      s_reg.fl_we <= 1'b0;
      s_reg.fl_wdata <= fsac_pkg::FSAC_WORD_RST;
      s_reg.fl_prog <= 1'b0;
      s_reg.fl_erase <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // busy tracks the write-start bit, so it is the same flip-flop
  assign RDATA_O = s_reg.rdata;
  assign FL_ADDR_O = s_reg.fl_addr;
  assign FL_CFG_O = s_reg.fl_cfg;
  assign FL_RD_O = s_reg.fl_rd;
  assign FL_WE_O = s_reg.fl_we;
  assign FL_WDATA_O = s_reg.fl_wdata;
  assign FL_PROG_O = s_reg.fl_prog;
  assign FL_ERASE_O = s_reg.fl_erase;
  assign BUSY_O = s_reg.wr;
endmodule // fsac_ctrl

/* File: dv/fsac_ctrl_asserts.sv */
// checker: timing of fsac_ctrl register reads and flash commands.
// assumes one clock and a synchronous reset on the ports of fsac_ctrl.
module fsac_ctrl_asserts (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic FL_DONE_I,
  input wire logic [14:0] FL_ADDR_O,
  input wire logic FL_CFG_O,
  input wire logic FL_RD_O,
  input wire logic FL_WE_O,
  input wire logic FL_PROG_O,
  input wire logic FL_ERASE_O,
  input wire logic BUSY_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  logic go_req, rd_req;
  assign go_req = WR_I && ADDR_I == 3'h4 && WDATA_I[2] && WDATA_I[1];
  assign rd_req = WR_I && ADDR_I == 3'h4 && WDATA_I[0];
  // an erase begins where busy rises together with the erase pulse
  sequence s_erase_go;
    $rose(BUSY_O) ##0 FL_ERASE_O;
  endsequence
  a_read_cause: assert property (FL_RD_O |-> $past(rd_req) ##1 !FL_RD_O)
    else $error("flash read not caused by a read-start write");
  a_addr_top: assert property (RD_I && ADDR_I == 3'h3 |=> RDATA_O[7])
    else $error("address high top bit not one");
  a_start_cause: assert property ($rose(BUSY_O) |-> $past(go_req))
    else $error("operation began without enabled write-start");
  a_latch_end: assert property ($fell(BUSY_O) && !$past(FL_DONE_I) |-> !$past(BUSY_O, 2))
    else $error("busy ended early without done");
  a_done_clear: assert property (BUSY_O && FL_DONE_I |=> !BUSY_O)
    else $error("busy not cleared after done");
  a_erase_row: assert property (s_erase_go |-> FL_ADDR_O[4:0] == 5'h00 && !FL_CFG_O)
    else $error("erase not at a row base");
  a_erase_only: assert property (s_erase_go |=> (!FL_WE_O && !FL_PROG_O) [*8])
    else $error("latch traffic during erase");
  a_prog_last: assert property (FL_PROG_O && !FL_CFG_O |-> FL_WE_O && FL_ADDR_O[4:0] == 5'h1F)
    else $error("program start not on the last latch");
endmodule // fsac_ctrl_asserts

bind fsac_ctrl fsac_ctrl_asserts chk_i (.MCLK_I(MCLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .FL_DONE_I(FL_DONE_I),
  .FL_ADDR_O(FL_ADDR_O), .FL_CFG_O(FL_CFG_O), .FL_RD_O(FL_RD_O), .FL_WE_O(FL_WE_O),
  .FL_PROG_O(FL_PROG_O), .FL_ERASE_O(FL_ERASE_O), .BUSY_O(BUSY_O));

/* File: dv/fsac_ctrl_test.sv */
// self-checking bench for fsac_ctrl: registers, reads, latch loads, program, erase.
// assumes the bench plays the flash macro: a fixed read word and done on request.
module fsac_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done = 1'b0, hit;
  logic [2:0] adr = 3'h0;
  logic [7:0] wd = 8'h00, rdat;
  logic [13:0] frd = 14'h2ABC, fwd;
  logic [14:0] fadr;
  logic fcfg, frdo, fwe, fprog, fers, busy;
  logic [13:0] got [32];
  logic [19:0] rows [7] = '{20'h0FFFF, 20'h1FF3F, 20'h2A5A5, 20'h3FFFF, 20'h30080,
    20'h5FF00, 20'h6FF00};
  int errors = 0, num_checks = 0, nwe, nprog;
  always #20 clk = ~clk;
  fsac_ctrl uut (.MCLK_I(clk), .SRST_I(rst), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .FL_RDATA_I(frd), .FL_DONE_I(done), .FL_ADDR_O(fadr),
    .FL_CFG_O(fcfg), .FL_RD_O(frdo), .FL_WE_O(fwe), .FL_WDATA_O(fwd), .FL_PROG_O(fprog),
    .FL_ERASE_O(fers), .BUSY_O(busy));
  task automatic chk(input string n, input logic [14:0] e, input logic [14:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic r(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("register read", {7'h00, e}, {7'h00, rdat});
  endtask
  task automatic go(input logic [7:0] d);
    w(3'h5, 8'h55);
    w(3'h5, 8'hAA);
    w(3'h4, d);
    #1;
  endtask
  task automatic sweep();
    nwe = 0;
    nprog = 0;
    foreach (got[i])
      got[i] = 14'h0000;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (fwe === 1'b1) begin
        got[fadr[4:0]] = fwd;
        nwe++;
      end
      if (fprog === 1'b1)
        nprog++;
    end
  endtask
  task automatic finish_op();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
  endtask
  task automatic prog(input logic [13:0] e3);
    go(8'h06);
    sweep();
    foreach (got[i])
      chk("latch word", i == 3 ? e3 : i == 5 ? 14'h0ABC : 14'h3FFF, got[i]);
    chk("program pulse", 1, nprog);
    w(3'h4, 8'h04);
    #1;
    chk("busy held", 1, busy);
    finish_op();
    chk("busy done", 0, busy);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    r(3'h3, 8'h80);
    r(3'h4, 8'h80);
    r(3'h5, 8'h00);
    foreach (rows[i]) begin
      w(rows[i][18:16], rows[i][15:8]);
      r(rows[i][18:16], rows[i][7:0]);
    end
    $display("register test done");
    w(3'h2, 8'h23);
    w(3'h3, 8'h01);
    go(8'h01);
    chk("read strobe", 1, frdo);
    chk("read address", 15'h0123, fadr);
    r(3'h0, 8'hBC);
    r(3'h1, 8'h2A);
    r(3'h4, 8'h80);
    w(3'h3, 8'h00);
    // the region select must be in place before the first read starts
    w(3'h4, 8'h40);
    for (int o = 3; o < 10; o++) begin
      hit = o != 4 && o < 9;
      w(3'h2, 8'(o));
      w(3'h4, 8'h41);
      #1;
      chk("config read", {14'h0000, hit}, {14'h0000, fcfg && frdo});
      r(3'h0, hit ? 8'hBC : 8'h00);
      r(3'h1, hit ? 8'h2A : 8'h00);
    end
    $display("read test done");
    go(8'h02);
    chk("start without enable", 0, busy);
    r(3'h4, 8'h88);
    w(3'h4, 8'h04);
    w(3'h5, 8'h55);
    w(3'h5, 8'hAA);
    w(3'h0, 8'h00);
    w(3'h4, 8'h06);
    #1;
    chk("broken unlock", 0, busy);
    w(3'h0, 8'h34);
    w(3'h1, 8'h12);
    w(3'h2, 8'h23);
    w(3'h3, 8'h01);
    go(8'h26);
    chk("latch load busy", 1, busy);
    r(3'h4, 8'hA4);
    w(3'h0, 8'hBC);
    w(3'h1, 8'h0A);
    w(3'h2, 8'h25);
    prog(14'h1234);
    r(3'h4, 8'h84);
    prog(14'h3FFF);
    $display("program test done");
    go(8'h36);
    chk("erase start", 1, fers);
    chk("erase row", 15'h0120, fadr);
    finish_op();
    r(3'h4, 8'hA4);
    w(3'h2, 8'h06);
    w(3'h3, 8'h00);
    go(8'h46);
    sweep();
    chk("config word writes", 4, nwe);
    chk("config id word", 0, got[6]);
    finish_op();
    $display("erase and config test done");
    end_of_test();
  end
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule // fsac_ctrl_test
